/* common/cks_pkg.sv */
// Functional notes
// RL1: Primary suppression removes the backing colour using hue, selectivity, chroma and luma amounts.
// RL2: At full chroma amount the backing chroma is driven to zero; the preset is 100% chroma, 0% luma.
// RL3: A larger primary luma amount pulls the luminance of backing-coloured areas further toward black.
// RL4: Flare compensation adds a small adjustable colour offset to every foreground pixel, typically under 2%.
// RL5: Key gain grows as the gap between the upper and lower clip levels shrinks.
// RL6: Keys above the upper clip level are fully opaque and keys below the lower one fully transparent.
// RL7: With key view on, the preview output carries the key signal instead of the picture.
// RL8: Key size and position act only while reshape is enabled.
// RL9: Size narrows the key and position shifts it horizontally left or right.
// RL10: Secondary suppression has its own hue, selectivity, angle, chroma and luma and acts only when enabled.
// RL11: A larger secondary selectivity narrows the band of hues that secondary suppression touches.
// RL12: With coring on, luma after primary suppression below the coring threshold becomes black.
// RL13: Fringe colour restoration of grey regions acts only while secondary suppression is on.
// RL14: Coring, fringe and shadow each have their own enable and may be combined freely.
// RL15: Shadow uses a clip and a gain to pick the luma range that casts shadow, and a density for opacity.
// RL16: Auto setup takes the backing colour as the average of a 16 by 16 pixel box at the cursor.
// RL17: Between the clip levels the key rises linearly from transparent to opaque.
`default_nettype none

package cks_pkg;

    // ------------------------------------------------------------------
    // Pipeline geometry
    // ------------------------------------------------------------------
    localparam int TAPS = 8;
    localparam int CENTER = 4;
    localparam logic [2:0] PRIME_CNT = 3'h4;
    localparam int TAP_W = 40;
    localparam int BUF_W = 64;
    localparam int F_Y = 32;
    localparam int F_CB = 24;
    localparam int F_CR = 16;
    localparam int F_KEY = 8;
    localparam int F_SHD = 0;

    // ------------------------------------------------------------------
    // Arithmetic scaling
    // ------------------------------------------------------------------
    localparam int HUE_FRAC = 7;
    localparam int SEL_SHIFT = 4;
    localparam int AMT_SHIFT = 15;
    localparam int LUMA_SHIFT = 8;
    localparam int FLARE_SHIFT = 10;
    localparam int SHADOW_SHIFT = 4;
    localparam int SHADOW_MIX_SHIFT = 16;
    localparam logic [8:0] FRINGE_GREY = 9'h010;
    localparam logic [7:0] FULL_OPAQUE = 8'hff;
    localparam logic [7:0] FULL_CLEAR = 8'h00;

    // ------------------------------------------------------------------
    // Auto setup sampling box
    // ------------------------------------------------------------------
    localparam logic [10:0] BOX_DIM = 11'h010;
    localparam logic [8:0] BOX_LAST = 9'h0ff;
    localparam int BOX_SHIFT = 8;

    typedef enum logic [2:0] {
        SU_IDLE = 3'b001,
        SU_ACCUM = 3'b010,
        SU_DONE = 3'b100
    } cks_setup_e;

endpackage

`default_nettype wire

/* hw/cks_buf.sv */
`default_nettype none

module cks_buf #(
    parameter int W = 64
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // Fill side
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [W-1:0] i_data,
    // Drain side
    output logic o_valid,
    input wire logic i_ready,
    output logic [W-1:0] o_data
);

    logic v1_r;
    logic [W-1:0] d1_r;
    logic take;
    logic pop;

    assign o_ready = !v1_r;
    assign take = i_valid && !v1_r;
    assign pop = o_valid && i_ready;

    // ------------------------------------------------------------------
    // Head and skid entries
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_valid <= 1'b0;
            v1_r <= 1'b0;
            o_data <= '0;
            d1_r <= '0;
        end else if (pop) begin
            if (v1_r) begin
                o_data <= d1_r;
                v1_r <= 1'b0;
            end else if (take) begin
                o_data <= i_data;
            end else begin
                o_valid <= 1'b0;
            end
        end else if (take) begin
            if (!o_valid) begin
                o_data <= i_data;
                o_valid <= 1'b1;
            end else begin
                d1_r <= i_data;
                v1_r <= 1'b1;
            end
        end
    end

    AST_BUF_HOLD: assert property (@(posedge i_clk_sys)
        disable iff (!i_resetn)
        o_valid && !i_ready |=> o_valid && $stable(o_data))
        else $error("Stalled output word changed or was lost.");

endmodule

`default_nettype wire

/* hw/cks_core.sv */
`default_nettype none

module cks_core (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // Foreground pixel stream in
    input wire logic i_pix_valid,
    output logic o_pix_ready,
    input wire logic [7:0] i_pix_y,
    input wire logic signed [7:0] i_pix_cb,
    input wire logic signed [7:0] i_pix_cr,
    input wire logic [10:0] i_pix_x,
    input wire logic [10:0] i_pix_line,
    // Processed stream out
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [7:0] o_fg_y,
    output logic [7:0] o_fg_cb,
    output logic [7:0] o_fg_cr,
    output logic [7:0] o_key,
    output logic [7:0] o_shadow,
    output logic [7:0] o_pvw_y,
    output logic [7:0] o_pvw_cb,
    output logic [7:0] o_pvw_cr,
    // Primary suppression and flare
    input wire logic signed [7:0] i_pri_hue_c,
    input wire logic signed [7:0] i_pri_hue_s,
    input wire logic [7:0] i_pri_sel,
    input wire logic [7:0] i_pri_chroma,
    input wire logic [7:0] i_pri_luma,
    input wire logic [7:0] i_flare_amt,
    // Key generator
    input wire logic [7:0] i_upper_clip_level,
    input wire logic [7:0] i_lower_clip_level,
    input wire logic i_key_view,
    input wire logic i_reshape_en,
    input wire logic [1:0] i_key_size,
    input wire logic signed [2:0] i_key_pos,
    // Secondary suppression
    input wire logic i_sec_en,
    input wire logic signed [7:0] i_sec_hue_c,
    input wire logic signed [7:0] i_sec_hue_s,
    input wire logic [7:0] i_sec_sel,
    input wire logic signed [7:0] i_sec_dir_c,
    input wire logic signed [7:0] i_sec_dir_s,
    input wire logic [7:0] i_sec_chroma,
    input wire logic [7:0] i_sec_luma,
    // Coring, fringe and shadow
    input wire logic i_coring_en,
    input wire logic [7:0] i_coring_thr,
    input wire logic i_fringe_en,
    input wire logic [7:0] i_fringe_amt,
    input wire logic i_shadow_en,
    input wire logic [7:0] i_shadow_clip,
    input wire logic [7:0] i_shadow_gain,
    input wire logic [7:0] i_shadow_density,
    // Auto setup
    input wire logic i_setup_go,
    input wire logic [10:0] i_cursor_x,
    input wire logic [10:0] i_cursor_y,
    output logic o_setup_busy,
    output logic o_setup_done,
    output logic [7:0] o_backing_y,
    output logic signed [7:0] o_backing_cb,
    output logic signed [7:0] o_backing_cr
);

    default clocking cb_sys @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_resetn);

    // ------------------------------------------------------------------
    // Arithmetic helpers
    // ------------------------------------------------------------------
    function automatic logic signed [17:0] dot(
        input logic signed [8:0] a, input logic signed [8:0] b,
        input logic signed [7:0] c, input logic signed [7:0] s);
        logic signed [17:0] acc;
        acc = 18'(a) * 18'(c) + 18'(b) * 18'(s);
        dot = acc >>> cks_pkg::HUE_FRAC;
    endfunction

    // Backing amount shrinks with hue distance scaled by selectivity.
    function automatic logic signed [17:0] backing(
        input logic signed [17:0] p, input logic signed [17:0] q,
        input logic [7:0] sel);
        logic signed [27:0] cut;
        logic signed [17:0] mag;
        mag = (q < 0) ? -q : q;
        cut = (28'(mag) * $signed({20'h0, sel})) >>> cks_pkg::SEL_SHIFT;
        backing = (28'(p) > cut) ? 18'(28'(p) - cut) : '0;
    endfunction

    function automatic logic signed [17:0] scale(
        input logic signed [17:0] b, input logic signed [7:0] v,
        input logic [7:0] amt);
        logic signed [35:0] prod;
        prod = 36'(b) * 36'(v) * $signed({28'h0, amt});
        scale = 18'(prod >>> cks_pkg::AMT_SHIFT);
    endfunction

    function automatic logic [7:0] sat_u8(input logic signed [17:0] v);
        if (v < 0) begin
            sat_u8 = 8'h00;
        end else if (v > 18'sd255) begin
            sat_u8 = 8'hff;
        end else begin
            sat_u8 = v[7:0];
        end
    endfunction

    function automatic logic signed [7:0] sat_s8(
        input logic signed [17:0] v);
        if (v < -18'sd128) begin
            sat_s8 = 8'h80;
        end else if (v > 18'sd127) begin
            sat_s8 = 8'h7f;
        end else begin
            sat_s8 = v[7:0];
        end
    endfunction

    function automatic logic [7:0] clip_key(
        input logic [7:0] raw, input logic [7:0] lo, input logic [7:0] hi);
        logic [15:0] num;
        logic [15:0] den;
        num = 16'(raw - lo) * 16'(cks_pkg::FULL_OPAQUE);
        den = 16'(hi - lo);
        if (raw >= hi) begin
            clip_key = cks_pkg::FULL_OPAQUE;
        end else if (raw <= lo) begin
            clip_key = cks_pkg::FULL_CLEAR;
        end else begin
            clip_key = 8'(num / den);
        end
    endfunction

    // ------------------------------------------------------------------
    // Suppression, key and shadow for the incoming pixel
    // ------------------------------------------------------------------
    logic signed [17:0] p1, q1, b1, p2, q2, b2;
    logic signed [17:0] cb1, cr1, cb2, cr2, cb3, cr3, y1, y2;
    logic [7:0] yc, raw_key, keyc, shd_lvl, shadow;
    logic [8:0] chroma_mag;
    logic signed [9:0] shd_diff;
    logic [23:0] shd_mix;

    always_comb begin
        p1 = dot(9'(i_pix_cb), 9'(i_pix_cr), i_pri_hue_c, i_pri_hue_s); // RL1
        q1 = dot(9'(i_pix_cr), -9'(i_pix_cb), i_pri_hue_c, i_pri_hue_s);
        b1 = backing(p1, q1, i_pri_sel); // RL1
        cb1 = 18'(i_pix_cb) - scale(b1, i_pri_hue_c, i_pri_chroma); // RL2
        cr1 = 18'(i_pix_cr) - scale(b1, i_pri_hue_s, i_pri_chroma); // RL2
        cb1 = cb1 - ((18'(i_pri_hue_c) * $signed({10'h0, i_flare_amt}))
            >>> cks_pkg::FLARE_SHIFT); // RL4
        cr1 = cr1 - ((18'(i_pri_hue_s) * $signed({10'h0, i_flare_amt}))
            >>> cks_pkg::FLARE_SHIFT); // RL4
        y1 = $signed({10'h0, i_pix_y}) - 18'((36'(b1)
            * $signed({28'h0, i_pri_luma})) >>> cks_pkg::LUMA_SHIFT); // RL3
        yc = sat_u8(y1);
        if (i_coring_en && yc < i_coring_thr) begin
            yc = 8'h00; // RL12
        end
        p2 = dot(9'(i_pix_cb), 9'(i_pix_cr), i_sec_hue_c, i_sec_hue_s);
        q2 = dot(9'(i_pix_cr), -9'(i_pix_cb), i_sec_hue_c, i_sec_hue_s);
        b2 = i_sec_en ? backing(p2, q2, i_sec_sel) : '0; // RL10 RL11
        cb2 = cb1 - scale(b2, i_sec_dir_c, i_sec_chroma); // RL10
        cr2 = cr1 - scale(b2, i_sec_dir_s, i_sec_chroma); // RL10
        y2 = $signed({10'h0, yc}) - 18'((36'(b2)
            * $signed({28'h0, i_sec_luma})) >>> cks_pkg::LUMA_SHIFT);
        chroma_mag = 9'((cb2 < 0) ? -cb2 : cb2) + 9'((cr2 < 0) ? -cr2 : cr2);
        cb3 = cb2;
        cr3 = cr2;
        if (i_fringe_en && i_sec_en && chroma_mag < cks_pkg::FRINGE_GREY) begin
            cb3 = cb2 + scale(b2, i_sec_dir_c, i_fringe_amt); // RL13 RL14
            cr3 = cr2 + scale(b2, i_sec_dir_s, i_fringe_amt); // RL13 RL14
        end
        raw_key = cks_pkg::FULL_OPAQUE - sat_u8(b1);
        keyc = clip_key(raw_key, i_lower_clip_level,
            i_upper_clip_level); // RL5 RL6 RL17
        shd_diff = $signed({2'b0, i_shadow_clip}) - $signed({2'b0, i_pix_y});
        shd_lvl = sat_u8(18'((18'(shd_diff) * $signed({10'h0, i_shadow_gain}))
            >>> cks_pkg::SHADOW_SHIFT)); // RL15
        shd_mix = 24'(shd_lvl) * 24'(i_shadow_density)
            * 24'(cks_pkg::FULL_OPAQUE - keyc); // RL15
        shadow = i_shadow_en ? 8'(shd_mix >> cks_pkg::SHADOW_MIX_SHIFT)
            : 8'h00; // RL14
    end

    // ------------------------------------------------------------------
    // Horizontal tap line for reshape
    // ------------------------------------------------------------------
    logic [cks_pkg::TAP_W-1:0] tap_r [0:cks_pkg::TAPS-1];
    logic [cks_pkg::TAP_W-1:0] new_word;
    logic [7:0] kt [0:cks_pkg::TAPS];
    logic [7:0] key_win;
    logic [2:0] fill_r;
    logic primed;
    logic accept;
    logic buf_in_valid;
    logic buf_in_ready;
    logic [cks_pkg::BUF_W-1:0] buf_in_data;
    logic [cks_pkg::BUF_W-1:0] buf_out_data;
    logic [cks_pkg::TAP_W-1:0] mid;
    int ctr;
    int sz;

    assign new_word = {sat_u8(y2), sat_s8(cb3), sat_s8(cr3), keyc, shadow};
    assign accept = i_pix_valid && buf_in_ready;
    assign primed = fill_r == cks_pkg::PRIME_CNT;
    assign o_pix_ready = buf_in_ready;
    assign buf_in_valid = i_pix_valid && primed;
    assign mid = tap_r[cks_pkg::CENTER-1];

    for (genvar g = 0; g < cks_pkg::TAPS; g++) begin : g_tap
        always_ff @(posedge i_clk_sys) begin
            if (!i_resetn) begin
                tap_r[g] <= '0;
            end else if (accept) begin
                if (g == 0) begin
                    tap_r[g] <= new_word;
                end else begin
                    tap_r[g] <= tap_r[(g == 0) ? 0 : g - 1];
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            fill_r <= 3'h0;
        end else if (accept && !primed) begin
            fill_r <= fill_r + 3'h1;
        end
    end

    // Older taps lie further left on the line, so a positive position
    // moves the key to the right.
    always_comb begin
        ctr = cks_pkg::CENTER + int'(i_key_pos);
        sz = int'(i_key_size);
        kt[0] = keyc;
        for (int i = 0; i < cks_pkg::TAPS; i++) begin
            kt[i + 1] = tap_r[i][cks_pkg::F_KEY +: 8];
        end
        key_win = kt[cks_pkg::CENTER];
        if (i_reshape_en) begin // RL8
            key_win = cks_pkg::FULL_OPAQUE;
            for (int i = 0; i <= cks_pkg::TAPS; i++) begin
                if (i >= ctr - sz && i <= ctr + sz && kt[i] < key_win) begin
                    key_win = kt[i]; // RL9
                end
            end
        end
    end

    always_comb begin
        buf_in_data = {mid[cks_pkg::F_Y +: 8], mid[cks_pkg::F_CB +: 8],
            mid[cks_pkg::F_CR +: 8], mid[cks_pkg::F_Y +: 8],
            mid[cks_pkg::F_CB +: 8], mid[cks_pkg::F_CR +: 8], key_win,
            mid[cks_pkg::F_SHD +: 8]};
        if (i_key_view) begin
            buf_in_data[63:40] = {key_win, 16'h0000}; // RL7
        end
    end

    cks_buf #(.W(cks_pkg::BUF_W)) u_buf (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_valid(buf_in_valid),
        .o_ready(buf_in_ready),
        .i_data(buf_in_data),
        .o_valid(o_out_valid),
        .i_ready(i_out_ready),
        .o_data(buf_out_data)
    );

    assign {o_pvw_y, o_pvw_cb, o_pvw_cr, o_fg_y, o_fg_cb, o_fg_cr, o_key,
        o_shadow} = buf_out_data;

    // ------------------------------------------------------------------
    // Auto setup backing sample
    // ------------------------------------------------------------------
    cks_pkg::cks_setup_e su_r;
    logic [8:0] cnt_r;
    logic [15:0] sum_y_r;
    logic signed [15:0] sum_cb_r, sum_cr_r;
    logic [10:0] dx, dy;
    logic in_box;

    assign dx = i_pix_x - i_cursor_x;
    assign dy = i_pix_line - i_cursor_y;
    assign in_box = i_pix_x >= i_cursor_x && dx < cks_pkg::BOX_DIM
        && i_pix_line >= i_cursor_y && dy < cks_pkg::BOX_DIM;
    assign o_setup_busy = su_r != cks_pkg::SU_IDLE;

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            su_r <= cks_pkg::SU_IDLE;
            cnt_r <= '0;
            sum_y_r <= '0;
            sum_cb_r <= '0;
            sum_cr_r <= '0;
            o_setup_done <= 1'b0;
            o_backing_y <= 8'h00;
            o_backing_cb <= 8'h00;
            o_backing_cr <= 8'h00;
        end else begin
            o_setup_done <= 1'b0;
            case (su_r)
                cks_pkg::SU_IDLE: begin
                    if (i_setup_go) begin
                        su_r <= cks_pkg::SU_ACCUM;
                        cnt_r <= '0;
                        sum_y_r <= '0;
                        sum_cb_r <= '0;
                        sum_cr_r <= '0;
                    end
                end
                cks_pkg::SU_ACCUM: begin
                    if (i_setup_go) begin
                        su_r <= cks_pkg::SU_IDLE;
                    end else if (accept && in_box) begin
                        sum_y_r <= sum_y_r + 16'(i_pix_y); // RL16
                        sum_cb_r <= sum_cb_r + 16'(i_pix_cb); // RL16
                        sum_cr_r <= sum_cr_r + 16'(i_pix_cr); // RL16
                        cnt_r <= cnt_r + 9'h001;
                        if (cnt_r == cks_pkg::BOX_LAST) begin
                            su_r <= cks_pkg::SU_DONE;
                        end
                    end
                end
                cks_pkg::SU_DONE: begin
                    o_backing_y <= 8'(sum_y_r >> cks_pkg::BOX_SHIFT); // RL16
                    o_backing_cb <= 8'(sum_cb_r >>> cks_pkg::BOX_SHIFT);
                    o_backing_cr <= 8'(sum_cr_r >>> cks_pkg::BOX_SHIFT);
                    o_setup_done <= 1'b1;
                    su_r <= cks_pkg::SU_IDLE;
                end
                default: begin
                    su_r <= cks_pkg::SU_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_last_sample;
        su_r == cks_pkg::SU_ACCUM && !i_setup_go && accept && in_box
            && cnt_r == cks_pkg::BOX_LAST;
    endsequence

    sequence s_finish;
        su_r == cks_pkg::SU_DONE ##1 o_setup_done && !o_setup_busy;
    endsequence

    AST_SETUP_AVG: assert property (s_last_sample |=> s_finish) // RL16
        else $error("Auto setup did not finish after the last box pixel.");
    AST_UPPER_CLIP_LEVEL: assert property (raw_key >= i_upper_clip_level // RL6
        |-> keyc == cks_pkg::FULL_OPAQUE)
        else $error("Key above upper clip is not opaque.");
    AST_CLIP_LO: assert property (raw_key <= i_lower_clip_level // RL6
        && raw_key < i_upper_clip_level |-> keyc == cks_pkg::FULL_CLEAR)
        else $error("Key below lower clip is not clear.");
    AST_CLIP_LIN: assert property (raw_key > i_lower_clip_level // RL17
        && raw_key < i_upper_clip_level
        |-> keyc < cks_pkg::FULL_OPAQUE && keyc > cks_pkg::FULL_CLEAR)
        else $error("Partial key left the linear range.");
    AST_LUMA_DOWN: assert property (b1 > 0 && i_pri_luma != 8'h00 // RL3
        && i_pix_y != 8'h00 |-> y1 < $signed({10'h0, i_pix_y}))
        else $error("Luma suppression did not darken the backing.");
    AST_CORING: assert property (i_coring_en && sat_u8(y1) < i_coring_thr // RL12
        && !i_sec_en |-> new_word[cks_pkg::F_Y +: 8] == 8'h00)
        else $error("Cored luma is not black.");
    AST_KEY_VIEW: assert property (i_key_view // RL7
        |-> buf_in_data[63:56] == key_win && buf_in_data[55:40] == '0)
        else $error("Preview does not carry the key.");
    AST_RESHAPE_OFF: assert property (!i_reshape_en // RL8
        |-> key_win == tap_r[cks_pkg::CENTER - 1][cks_pkg::F_KEY +: 8])
        else $error("Key moved while reshape is off.");
    AST_SEC_OFF: assert property (!i_sec_en |-> cb3 == cb1 && cr3 == cr1) // RL10
        else $error("Secondary or fringe acted while disabled.");
    AST_SHADOW_OFF: assert property (!i_shadow_en // RL14
        |-> new_word[cks_pkg::F_SHD +: 8] == 8'h00)
        else $error("Shadow generated while disabled.");

endmodule

`default_nettype wire

/* tb/chroma_key_suppressor_bench.sv */
`default_nettype none

module chroma_key_suppressor_bench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        logic dc, v;
        logic [7:0] k, y, cb, sh;
        int tol;
    } cks_exp_s;
    typedef struct packed {
        logic [7:0] y, cb, chr, lum, hi, lo;
        logic [3:0] m;
        logic [7:0] k, ey, ecb, sh, tol;
    } cks_row_s;
    logic i_clk_sys = 1'b0, i_resetn = 1'b0, i_pix_valid = 1'b0;
    logic [7:0] i_pix_y = 8'h00;
    logic signed [7:0] i_pix_cb = 8'sh00, i_pix_cr = 8'sh00;
    logic [10:0] i_pix_x = 11'h000, i_pix_line = 11'h000;
    logic signed [7:0] i_pri_hue_c = 8'sh7f, i_pri_hue_s = 8'sh00;
    logic [7:0] i_pri_sel = 8'h00, i_pri_chroma = 8'hff, i_pri_luma = 8'h00;
    logic [7:0] i_flare_amt = 8'h00, i_sec_sel = 8'h00, i_sec_chroma = 8'h00;
    logic [7:0] i_upper_clip_level = 8'hf0, i_lower_clip_level = 8'hc8;
    logic i_key_view = 1'b0, i_reshape_en = 1'b0, i_sec_en = 1'b0;
    logic [1:0] i_key_size = 2'h0;
    logic signed [2:0] i_key_pos = 3'sh0;
    logic signed [7:0] i_sec_hue_c = 8'sh7f, i_sec_hue_s = 8'sh00;
    logic signed [7:0] i_sec_dir_c = 8'sh00, i_sec_dir_s = 8'sh00;
    logic [7:0] i_sec_luma = 8'h00, i_coring_thr = 8'h40, i_fringe_amt = 8'h00;
    logic [7:0] i_shadow_clip = 8'h80, i_shadow_gain = 8'h10;
    logic [7:0] i_shadow_density = 8'hff;
    logic i_coring_en = 1'b0, i_fringe_en = 1'b0, i_shadow_en = 1'b0;
    logic i_setup_go = 1'b0, stall = 1'b0, slow = 1'b0, got_done = 1'b0;
    logic [10:0] i_cursor_x = 11'h002, i_cursor_y = 11'h001;
    logic o_pix_ready, o_out_valid, i_out_ready, o_setup_busy, o_setup_done;
    logic [7:0] o_fg_y, o_fg_cb, o_fg_cr, o_key, o_shadow, o_backing_y;
    logic [7:0] o_pvw_y, o_pvw_cb, o_pvw_cr, bk_y, bk_cb;
    logic signed [7:0] o_backing_cb, o_backing_cr;
    cks_exp_s q[$];
    cks_exp_s ex, dcx = '{1'b1, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 0};
    int klog[$];
    int fail_count = 0, n_checks = 0, c, j, k, z, f, f1;
    cks_row_s rows [10] = '{
        92'h80_00_ff_00_f0_c8_0_ff_80_00_00_02,
        92'h80_64_ff_00_f0_c8_0_00_80_00_00_03,
        92'h80_64_ff_00_c8_64_0_8e_80_00_00_04,
        92'h80_64_ff_00_aa_8c_0_88_80_00_00_0a,
        92'h80_00_ff_00_f0_c8_1_ff_80_00_00_02,
        92'h30_00_ff_00_f0_c8_2_ff_00_00_00_02,
        92'h50_00_ff_00_f0_c8_2_ff_50_00_00_02,
        92'h20_64_ff_00_f0_c8_4_00_20_00_5f_03,
        92'h80_64_ff_ff_f0_c8_0_00_40_00_00_3f,
        92'h80_64_00_00_f0_c8_0_00_80_64_00_02
    };

    cks_core dut (.*);
    cks_sink sink (.i_clk_sys(i_clk_sys), .i_stall(stall), .i_slow(slow),
        .o_ready(i_out_ready));

    always #5 i_clk_sys = !i_clk_sys;

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic tmo;
        fail_count++;
        $display("Error %0t wait ran out", $time);
        end_sim();
    endtask

    task automatic near(input logic [7:0] got, w, input int tol, input bit sg);
        int d;
        d = sg ? int'($signed(got)) - int'($signed(w)) : int'(got) - int'(w);
        n_checks++;
        if ((^got) === 1'bx || d > tol || d < -tol) begin
            fail_count++;
            $display("Error %0t got %h want %h", $time, got, w);
        end
    endtask

    task automatic same(input logic [7:0] got, w);
        near(got, w, 0, 1'b0);
    endtask

    task automatic send(input logic [7:0] y, cb, input cks_exp_s e);
        i_pix_valid = 1'b1;
        i_pix_y = y;
        i_pix_cb = cb;
        for (k = 0; k < 200 && o_pix_ready !== 1'b1; k++) @(posedge i_clk_sys) #1;
        if (k == 200) tmo();
        @(posedge i_clk_sys) #1;
        q.push_back(e);
    endtask

    task automatic drain;
        i_pix_valid = 1'b0;
        for (k = 0; k < 500 && q.size() > 4; k++) @(posedge i_clk_sys) #1;
        if (k == 500) tmo();
    endtask

    // ---------------------------------------------------------------
    // Output monitor
    // ---------------------------------------------------------------
    always @(posedge i_clk_sys) begin
        cks_exp_s e;
        if (o_setup_done === 1'b1) begin
            got_done <= 1'b1;
            bk_y <= o_backing_y;
            bk_cb <= o_backing_cb;
        end
        if (o_out_valid === 1'b1 && i_out_ready === 1'b1) begin
            e = q.pop_front();
            if (e.dc) klog.push_back(int'(o_key));
            else begin
                near(o_key, e.k, e.tol, 1'b0);
                near(o_fg_y, e.y, e.tol, 1'b0);
                near(o_fg_cb, e.cb, e.tol, 1'b1);
                near(o_fg_cr, 8'h00, e.tol, 1'b1);
                near(o_shadow, e.sh, e.tol, 1'b0);
                same(o_pvw_y, e.v ? o_key : o_fg_y);
                same(o_pvw_cb, e.v ? 8'h00 : o_fg_cb);
                same(o_pvw_cr, e.v ? 8'h00 : o_fg_cr);
            end
        end
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (12) @(posedge i_clk_sys);
        #1;
        same(o_out_valid, 8'h00);
        same(o_pix_ready, 8'h01);
        same(o_setup_busy, 8'h00);
        i_resetn = 1'b1;
        $display("reset test done");
        foreach (rows[i]) begin
            i_pri_chroma = rows[i].chr;
            i_pri_luma = rows[i].lum;
            i_upper_clip_level = rows[i].hi;
            i_lower_clip_level = rows[i].lo;
            i_key_view = rows[i].m[0];
            i_coring_en = rows[i].m[1];
            i_shadow_en = rows[i].m[2];
            ex = '{1'b0, rows[i < 6 ? i + 4 : 9].m[0], rows[i].k, rows[i].ey,
                rows[i].ecb, rows[i].sh, int'(rows[i].tol)};
            send(rows[i].y, rows[i].cb, ex);
        end
        $display("table test done");
        slow = 1'b1;
        for (c = 0; c < 3; c++) begin
            drain();
            klog.delete();
            i_reshape_en = (c != 0);
            i_key_size = 2'h1;
            i_key_pos = (c == 2) ? 3'sh1 : 3'sh0;
            for (j = 0; j < 28; j++) send(8'h80, (j == 8) ? 8'h64 : 8'h00, dcx);
            drain();
            z = 0;
            f = -1;
            foreach (klog[i]) if (klog[i] == 0) begin
                z++;
                if (f < 0) f = i;
            end
            same(8'(z), (c == 0) ? 8'h01 : 8'h03);
            if (c == 2) same(8'((f - f1) * (f - f1)), 8'h01);
            f1 = f;
        end
        $display("reshape test done");
        stall = 1'b1;
        for (j = 0; j < 12 && o_pix_ready === 1'b1; j++) send(8'h80, 8'h00, dcx);
        same(o_pix_ready, 8'h00);
        stall = 1'b0;
        slow = 1'b0;
        $display("stall test done");
        i_reshape_en = 1'b0;
        i_pix_valid = 1'b0;
        i_setup_go = 1'b1;
        @(posedge i_clk_sys) #1;
        i_setup_go = 1'b0;
        same(o_setup_busy, 8'h01);
        for (j = 0; j < 360; j++) begin
            i_pix_x = 11'(j % 20);
            i_pix_line = 11'(j / 20);
            z = (j % 20 >= 2 && j % 20 < 18 && j / 20 >= 1 && j / 20 < 17);
            send(z ? 8'h50 : 8'hff, z ? 8'hec : 8'h40, dcx);
        end
        drain();
        for (k = 0; k < 20 && got_done !== 1'b1; k++) @(posedge i_clk_sys) #1;
        if (k == 20) tmo();
        same(bk_y, 8'h50);
        same(bk_cb, 8'hec);
        same(o_backing_cr, 8'h00);
        same(8'(q.size()), 8'h04);
        $display("setup test done");
        end_sim();
    end
endmodule

`default_nettype wire

/* tb/cks_sink.sv */
`default_nettype none

module cks_sink (
    // Clock
    input wire logic i_clk_sys,
    // Pacing controls
    input wire logic i_stall,
    input wire logic i_slow,
    // Accept towards the keyer output
    output logic o_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic ph_r = 1'b0;

    // A slow mixer takes a word only every other cycle.
    always_ff @(posedge i_clk_sys) begin
        ph_r <= !ph_r;
    end
    assign o_ready = !i_stall && (ph_r || !i_slow);
endmodule

`default_nettype wire
